// ===== rtl/arith_shift_datapath.sv
// Shift datapath with register file, scratch memory and AXI4-Lite slave
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module arith_shift_datapath (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output shift_pkg::flags_t flags_out
);

  // Write and read channel state
  logic aw_held_r;
  logic [7:0] awaddr_r;
  logic w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Architectural state
  shift_pkg::cmd_t cmd_r;
  shift_pkg::flags_t flags_r;
  shift_pkg::flags_t flags_nxt;
  logic [31:0] imm_r;
  logic exec_r;
  logic [31:0] reg_q [0:15];
  logic [31:0] mem_q [0:15];

  // Decoded bus accesses
  logic wr_commit;
  logic rd_take;
  logic w_hit_cmd;
  logic w_hit_flags;
  logic w_hit_imm;
  logic w_hit_reg;
  logic w_hit_mem;
  logic w_mapped;
  logic [3:0] w_idx;
  logic [31:0] w_merged;
  logic r_hit_cmd;
  logic r_hit_flags;
  logic r_hit_imm;
  logic r_hit_reg;
  logic r_hit_mem;
  logic r_mapped;
  logic [3:0] r_idx;
  logic [31:0] rdata_nxt;

  // Operand fetch for the execute cycle
  logic [3:0] dst_idx;
  logic [3:0] cnt_reg_idx;
  logic [3:0] st_src_idx;
  logic [31:0] count_val;
  logic [31:0] src_val;
  logic [31:0] store_val;
  logic paired;
  logic dst_extended;
  shift_pkg::shift_out_t sh;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        m[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return m;
  endfunction

  // Channel handshakes; a write waits until the response has gone
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign wr_commit = aw_held_r && w_held_r && !bvalid_r;
  assign rd_take = arvalid && arready;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign flags_out = flags_r;

  // Write address decode
  assign w_idx = awaddr_r[5:2];
  assign w_hit_cmd = (awaddr_r == shift_pkg::OFF_CMD);
  assign w_hit_flags = (awaddr_r == shift_pkg::OFF_FLAGS);
  assign w_hit_imm = (awaddr_r == shift_pkg::OFF_IMM);
  assign w_hit_reg = (awaddr_r[7:6] == shift_pkg::WIN_REG);
  assign w_hit_mem = (awaddr_r[7:6] == shift_pkg::WIN_MEM);
  assign w_mapped = w_hit_cmd || w_hit_flags || w_hit_imm || w_hit_reg ||
                    w_hit_mem;

  // Read address decode
  assign r_idx = araddr[5:2];
  assign r_hit_cmd = (araddr == shift_pkg::OFF_CMD);
  assign r_hit_flags = (araddr == shift_pkg::OFF_FLAGS);
  assign r_hit_imm = (araddr == shift_pkg::OFF_IMM);
  assign r_hit_reg = (araddr[7:6] == shift_pkg::WIN_REG);
  assign r_hit_mem = (araddr[7:6] == shift_pkg::WIN_MEM);
  assign r_mapped = r_hit_cmd || r_hit_flags || r_hit_imm || r_hit_reg ||
                    r_hit_mem;

  // Read data selection, unmapped reads return zero
  assign rdata_nxt = r_hit_cmd ? {7'h00, exec_r, cmd_r} :
                     r_hit_flags ? {24'h000000, flags_r} :
                     r_hit_imm ? imm_r :
                     r_hit_reg ? reg_q[r_idx] :
                     r_hit_mem ? mem_q[r_idx] : 32'h00000000;

  // Write data after byte enables, against the current target word
  assign w_merged = w_hit_cmd ? merge_bytes({8'h00, cmd_r}, wdata_r, wstrb_r) :
                    w_hit_flags ? merge_bytes({24'h000000, flags_r}, wdata_r,
                                              wstrb_r) :
                    w_hit_imm ? merge_bytes(imm_r, wdata_r, wstrb_r) :
                    w_hit_reg ? merge_bytes(reg_q[w_idx], wdata_r, wstrb_r) :
                    merge_bytes(mem_q[w_idx], wdata_r, wstrb_r);

  // Operand selection, all from state as it stood before the edge
  assign paired = (cmd_r.op == shift_pkg::OP_PAIRED);
  assign dst_idx = paired ? {1'b0, cmd_r.dst[2:0]} : cmd_r.dst;
  assign cnt_reg_idx = paired ? {1'b0, cmd_r.cnt_sel[2:0]} : cmd_r.cnt_sel;
  assign st_src_idx = {1'b0, cmd_r.store_src[2:0]};
  assign dst_extended = (dst_idx < 4'(shift_pkg::EXT_REGS));
  // Store value is the register content before the shift writes it
  assign store_val = reg_q[st_src_idx];

  // Count source by form and addressing mode
  always_comb
  begin
    case (cmd_r.op)
      shift_pkg::OP_TWO:
      begin
        case (cmd_r.mode)
          2'h0: count_val = reg_q[cmd_r.cnt_sel];
          2'h1: count_val = mem_q[cmd_r.cnt_sel];
          2'h2: count_val = mem_q[cmd_r.cnt_sel];
          default: count_val = imm_r;
        endcase
      end
      shift_pkg::OP_THREE:
      begin
        // Low mode bit picks memory for the count
        count_val = cmd_r.mode[0] ? mem_q[cmd_r.cnt_sel] :
                    reg_q[cmd_r.cnt_sel];
      end
      default:
      begin
        count_val = reg_q[cnt_reg_idx];
      end
    endcase
  end

  // Shift source by form and addressing mode
  always_comb
  begin
    case (cmd_r.op)
      shift_pkg::OP_TWO:
      begin
        src_val = reg_q[cmd_r.dst];
      end
      shift_pkg::OP_THREE:
      begin
        // High mode bit picks memory for the source
        src_val = cmd_r.mode[1] ? mem_q[cmd_r.src_sel] :
                  reg_q[cmd_r.src_sel];
      end
      default:
      begin
        // Memory source read in the same cycle the store targets it
        src_val = mem_q[cmd_r.src_sel];
      end
    endcase
  end

  arith_shifter u_shifter (
    .count(count_val),
    .operand(src_val),
    .result(sh)
  );

  // Flag update for an executed shift; no saturation path exists
  always_comb
  begin
    flags_nxt = flags_r;
    if (exec_r)
    begin
      flags_nxt.n = sh.res[31];
      flags_nxt.z = (sh.res == 32'h00000000);
      flags_nxt.uf = 1'b0;
      flags_nxt.v = sh.ovf;
      flags_nxt.lv = flags_r.lv || sh.ovf;
      if (paired || dst_extended)
      begin
        flags_nxt.c = sh.carry;
      end
    end
    else if (wr_commit && w_hit_flags)
    begin
      flags_nxt = w_merged[7:0];
    end
  end

  // Write address and data holding registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= shift_pkg::WORD_RST;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= {awaddr[7:2], 2'h0};
      end
      else if (wr_commit)
      begin
        aw_held_r <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      else if (wr_commit)
      begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= shift_pkg::RESP_OKAY;
    end
    else if (wr_commit)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= w_mapped ? shift_pkg::RESP_OKAY : shift_pkg::RESP_DECERR;
    end
    else if (bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // Read data and response, one cycle after the address
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= shift_pkg::WORD_RST;
      rresp_r <= shift_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rdata_nxt;
      rresp_r <= r_mapped ? shift_pkg::RESP_OKAY : shift_pkg::RESP_DECERR;
    end
    else if (rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  // Command, immediate and launch; the shift runs in the next cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cmd_r <= shift_pkg::CMD_RST;
      imm_r <= shift_pkg::WORD_RST;
      exec_r <= 1'b0;
    end
    else
    begin
      exec_r <= wr_commit && w_hit_cmd &&
                (w_merged[1:0] != shift_pkg::OP_NONE);
      if (wr_commit && w_hit_cmd)
      begin
        cmd_r <= w_merged[23:0];
      end
      if (wr_commit && w_hit_imm)
      begin
        imm_r <= w_merged;
      end
    end
  end

  // Flags register; saturate select is stored but never read by the shift
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      flags_r <= shift_pkg::FLAGS_RST;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  // Register file and memory: shift and store land at one edge
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < shift_pkg::WIN_WORDS; i++)
      begin
        reg_q[i] <= shift_pkg::WORD_RST;
        mem_q[i] <= shift_pkg::WORD_RST;
      end
    end
    else if (exec_r)
    begin
      reg_q[dst_idx] <= sh.res;
      if (paired)
      begin
        mem_q[cmd_r.store_dst] <= store_val;
      end
    end
    else if (wr_commit && w_hit_reg)
    begin
      reg_q[w_idx] <= w_merged;
    end
    else if (wr_commit && w_hit_mem)
    begin
      mem_q[w_idx] <= w_merged;
    end
  end

endmodule

// ===== rtl/arith_shifter.sv
// Combinational arithmetic barrel shifter with shift-out and overflow
`timescale 1ns/1ps
module arith_shifter (
  input wire logic [31:0] count,
  input wire logic [31:0] operand,
  output shift_pkg::shift_out_t result
);

  logic [6:0] amt;
  logic [6:0] mag;
  logic is_zero;
  logic is_left;
  logic [95:0] left_sx;
  logic [95:0] left_zx;
  logic [127:0] right_w;
  logic left_carry;
  logic left_ovf;

  // Signed amount from the low seven count bits only
  assign amt = count[6:0];
  assign mag = amt[6] ? (~amt + 7'h01) : amt;
  assign is_zero = (amt == 7'h00);
  assign is_left = !amt[6] && !is_zero;

  // Left shift, zeros enter at the bottom
  assign left_sx = {{64{operand[31]}}, operand} << mag;
  assign left_zx = {64'h0, operand} << mag;
  // Last bit out is the one that passed bit 32; past the span a zero
  assign left_carry = (mag > shift_pkg::SHIFT_SPAN) ? 1'b0 : left_zx[32];
  // Any bit moved out that differs from the old sign, or the new sign differing from the old sign
  assign left_ovf = |(left_sx[95:31] ^ {65{operand[31]}});

  // Right shift, sign bits enter at the top, leaving bits land at bit 31;
  // the sign field covers the full 64-step magnitude so no zero enters
  assign right_w = {{64{operand[31]}}, operand, 32'h0} >> mag;

  // Select the result for the sign of the amount
  always_comb
  begin
    if (is_zero)
    begin
      result.res = operand;
      result.carry = 1'b0;
      result.ovf = 1'b0;
    end
    else if (is_left)
    begin
      result.res = left_sx[31:0];
      result.carry = left_carry;
      result.ovf = left_ovf;
    end
    else
    begin
      result.res = right_w[63:32];
      result.carry = right_w[31];
      result.ovf = 1'b0;
    end
  end

endmodule

// ===== rtl/shift_pkg.sv
// Shared constants, register map and carrier types of the shift datapath
package shift_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int AMT_W = 7;
  localparam int WIN_WORDS = 16;
  localparam int EXT_REGS = 8;

  // Register map, byte addresses
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_IMM = 8'h08;
  localparam logic [1:0] WIN_REG = 2'h1;
  localparam logic [1:0] WIN_MEM = 2'h2;

  // Longest shift that still moves operand bits out
  localparam logic [6:0] SHIFT_SPAN = 7'h20;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    OP_TWO,
    OP_THREE,
    OP_PAIRED,
    OP_NONE
  } op_t;

  typedef struct packed {
    logic [3:0] store_dst;
    logic [3:0] store_src;
    logic [3:0] src_sel;
    logic [3:0] cnt_sel;
    logic [3:0] dst;
    logic [1:0] mode;
    op_t op;
  } cmd_t;

  typedef struct packed {
    logic sat_sel;
    logic sticky_underflow;
    logic lv;
    logic uf;
    logic n;
    logic z;
    logic v;
    logic c;
  } flags_t;

  typedef struct packed {
    logic [31:0] res;
    logic carry;
    logic ovf;
  } shift_out_t;

  localparam logic [23:0] CMD_RST = 24'h000003;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h00000000;

endpackage

// ===== testbench/bus_master.sv
// Register bus master standing in for the decoder and register file
`timescale 1ns/1ps
module bus_master (
  input wire logic sys_clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic stuck
);
  int n;
  logic fin;
  // Idle bus at time zero
  initial {awvalid, wvalid, bready, arvalid, rready, stuck} = 6'h00;
  initial {awaddr, wdata, araddr} = 48'h0;
  // Write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    fin = 1'b0;
    while (!fin && n < 200)
    begin
      @(posedge sys_clk);
      n++;
      if (awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        fin = 1'b1;
      end
    end
    stuck <= !fin;
  endtask
  // Read: address held until taken, answer taken with rready high
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    fin = 1'b0;
    while (!fin && n < 200)
    begin
      @(posedge sys_clk);
      n++;
      if (arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        fin = 1'b1;
      end
    end
    stuck <= !fin;
  endtask
endmodule

// ===== testbench/shift_checker.sv
// Handshake and flag checks bound to the shift datapath
`timescale 1ns/1ps
module shift_checker (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire shift_pkg::flags_t flags_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Write launch and its answer one cycle after commit
  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence answer_late;
    !bvalid ##1 bvalid;
  endsequence
  // Software flag write shows with the rising answer
  sequence sw_write;
    $rose(bvalid);
  endsequence
  a_write_answer: assert property (both_taken |=> answer_late)
    else $error("write answer not two cycles after request");
  a_write_block: assert property (bvalid |-> !awready && !wready)
    else $error("write channel open while answer pending");
  a_resp_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer kept after acceptance");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  a_reset_clear: assert property (
    $rose(rst_b) |-> flags_out == 8'h00 && !bvalid && !rvalid)
    else $error("state not cleared by reset");
  a_flags_quiet: assert property (
    $changed(flags_out) |-> bvalid || $past(bvalid))
    else $error("flags changed outside a write");
  a_lv_sticky: assert property ($fell(flags_out.lv) |-> sw_write)
    else $error("sticky limit flag dropped by a shift");
  a_uf_clear: assert property ($rose(flags_out.uf) |-> sw_write)
    else $error("underflow flag set by a shift");
  a_sat_kept: assert property (
    $changed(flags_out.sat_sel) |-> sw_write)
    else $error("saturate select changed by a shift");
endmodule

bind arith_shift_datapath shift_checker shift_checker_i (
  .sys_clk(sys_clk), .rst_b(rst_b), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .flags_out(flags_out)
);

// ===== testbench/testbench.sv
// Self-checking bench for the arithmetic shift datapath
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, stuck;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp, r;
  shift_pkg::flags_t flags_out;
  int n_errors = 0;
  int checks = 0;

  // Clock at 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  arith_shift_datapath arith_shift_datapath_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .flags_out(flags_out)
  );

  bus_master bus_master_i (
    .sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .stuck(stuck)
  );

  // Closing report
  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  // Only the hole at F0 is used as an unmapped place
  function automatic logic [1:0] er(input logic [7:0] a);
    return (a == 8'hF0) ? shift_pkg::RESP_DECERR : shift_pkg::RESP_OKAY;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_master_i.wr(a, d, r);
    chk("bresp", {30'h0, er(a)}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input string s);
    bus_master_i.rd(a, v, r);
    chk(s, e, v);
    chk("rresp", {30'h0, er(a)}, {30'h0, r});
  endtask

  // Shift R2 by R1 into R3, then check result and flags
  task automatic sh(input bit p, input logic [31:0] c, s, e,
    input logic [7:0] f);
    if (p)
      wr(8'h04, 32'hD0);
    wr(8'h44, c);
    wr(8'h48, s);
    wr(8'h00, 32'h2131);
    rd(8'h4C, e, "result");
    rd(8'h04, {24'h0, f}, "flags");
    chk("flags_out", {24'h0, f}, {24'h0, flags_out});
  endtask

  // A bus wait that ran out ends the run
  always @(posedge stuck)
  begin
    n_errors++;
    test_done();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rd(8'h00, 32'h3, "cmd");
    rd(8'h04, 32'h0, "flags");
    wr(8'hF0, 32'h5A);
    rd(8'hF0, 32'h0, "hole");
    sh(1, 32'h10, 32'h000AE000, 32'hE0000000, 8'hEA);
    sh(0, 32'h7F, 32'h3, 32'h1, 8'hE1);
    sh(1, 32'hFFE8, 32'hAEC00001, 32'hFFFFFFAE, 8'hC9);
    sh(1, 32'h0, 32'h80000001, 32'h80000001, 8'hC8);
    sh(1, 32'h20, 32'h1, 32'h0, 8'hE7);
    sh(1, 32'h60, 32'h80000000, 32'hFFFFFFFF, 8'hC9);
    sh(1, 32'h80, 32'h12345678, 32'h12345678, 8'hC0);
    sh(1, 32'h40, 32'h80000000, 32'hFFFFFFFF, 8'hC9);
    sh(1, 32'h1, 32'h40000000, 32'h80000000, 8'hEA);
    sh(1, 32'h21, 32'hFFFFFFFF, 32'h0, 8'hE6);
    // Destination outside the extended set keeps the carry
    wr(8'h04, 32'h01);
    wr(8'h44, 32'h0);
    wr(8'h00, 32'h2191);
    rd(8'h64, 32'hFFFFFFFF, "r9");
    rd(8'h04, 32'h09, "flags");
    // Two-operand shift by immediate
    wr(8'h08, 32'h7E);
    wr(8'h50, 32'h100);
    wr(8'h00, 32'h4C);
    rd(8'h50, 32'h40, "r4");
    // Three-operand count and source from memory
    wr(8'h84, 32'h4);
    wr(8'h88, 32'h11);
    wr(8'h00, 32'h213D);
    rd(8'h4C, 32'h110, "r3");
    // Three-operand count from a register, source from memory
    wr(8'h44, 32'h2);
    wr(8'h00, 32'h2139);
    rd(8'h4C, 32'h44, "r3");
    // Two-operand count from memory, then from a register
    wr(8'h00, 32'h144);
    rd(8'h50, 32'h400, "r4");
    wr(8'h00, 32'h140);
    rd(8'h50, 32'h1000, "r4");
    // Paired shift and store sharing a register and a memory word
    wr(8'h44, 32'h4);
    wr(8'h8C, 32'hF);
    wr(8'h54, 32'hAAAA0000);
    wr(8'h00, 32'h353152);
    rd(8'h54, 32'hF0, "r5");
    rd(8'h8C, 32'hAAAA0000, "mem3");
    test_done();
  end
endmodule
